// File: inc/sfseq_regs.vh
// constants of the serial flash command sequencer
`ifndef SFSEQ_REGS_VH
`define SFSEQ_REGS_VH

// ----
// opcodes
// ----
`define SFSEQ_OP_READ 8'h03
`define SFSEQ_OP_FAST_READ 8'h0b
`define SFSEQ_OP_PROGRAM 8'h02
`define SFSEQ_OP_SEQ_PROGRAM 8'haf
`define SFSEQ_OP_SECTOR_ERASE 8'h20
`define SFSEQ_OP_BLOCK_ERASE_A 8'h52
`define SFSEQ_OP_BLOCK_ERASE_B 8'hd8
`define SFSEQ_OP_CHIP_ERASE_A 8'h60
`define SFSEQ_OP_CHIP_ERASE_B 8'hc7
`define SFSEQ_OP_WRITE_UNLOCK 8'h06
`define SFSEQ_OP_WRITE_LOCK 8'h04
`define SFSEQ_OP_STATUS_READ 8'h05
`define SFSEQ_OP_STATUS_ARM 8'h50
`define SFSEQ_OP_STATUS_WRITE 8'h01
`define SFSEQ_OP_ID_READ_A 8'h90
`define SFSEQ_OP_ID_READ_B 8'hab

// ----
// address map and protection
// ----
`define SFSEQ_SECTOR_MASK 16'h0fff
`define SFSEQ_BLOCK_MASK 16'h7fff
`define SFSEQ_PROT_QUARTER_BASE 16'hc000
`define SFSEQ_PROT_HALF_BASE 16'h8000
`define SFSEQ_TOP_ADDR 16'hffff
`define SFSEQ_TOP_QUARTER 16'hbfff
`define SFSEQ_TOP_HALF 16'h7fff

// ----
// erase kinds
// ----
`define SFSEQ_ERASE_SECTOR 2'h0
`define SFSEQ_ERASE_BLOCK 2'h1
`define SFSEQ_ERASE_CHIP 2'h2

// ----
// status byte fields
// ----
`define SFSEQ_ST_BUSY 0
`define SFSEQ_ST_LATCH 1
`define SFSEQ_ST_SEQ 6

// ----
// self-timed durations in 10 ns clock cycles
// ----
`define SFSEQ_BYTE_PROGRAM_CYCLES 24'h0007d0
`define SFSEQ_SECTOR_ERASE_CYCLES 24'h2625a0
`define SFSEQ_BLOCK_ERASE_CYCLES 24'h2625a0
`define SFSEQ_CHIP_ERASE_CYCLES 24'h989680

`endif

// File: hw/sfseq_sync.v
// pin synchroniser and edge finder for the serial port
`timescale 1ns/100ps
`default_nettype none
module sfseq_sync (
  input wire clock, // system clock
  input wire nrst, // sync reset, active low
  input wire sck, // serial clock pin
  input wire cs_n, // chip select pin, active low
  input wire mosi, // serial data in pin
  output reg sck_rise, // one-cycle pulse
  output reg sck_fall, // one-cycle pulse
  output reg cs_fall, // one-cycle pulse
  output reg cs_rise, // one-cycle pulse
  output reg mosi_s // synchronised data in
);
  reg [1:0] sck_q;
  reg [1:0] cs_q;
  reg [1:0] mosi_q;
  reg sck_last_q;
  reg cs_last_q;

  // ----------------------------------------
  // two stages, then edges from the second only
  // ----------------------------------------
  // equal depth on all three keeps data aligned with the clock edge
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      sck_q <= 2'h0;
      cs_q <= 2'h3;
      mosi_q <= 2'h0;
      sck_last_q <= 1'b0;
      cs_last_q <= 1'b1;
      sck_rise <= 1'b0;
      sck_fall <= 1'b0;
      cs_fall <= 1'b0;
      cs_rise <= 1'b0;
      mosi_s <= 1'b0;
    end
    else
    begin
      sck_q <= {sck_q[0], sck};
      cs_q <= {cs_q[0], cs_n};
      mosi_q <= {mosi_q[0], mosi};
      sck_last_q <= sck_q[1];
      cs_last_q <= cs_q[1];
      sck_rise <= sck_q[1] & ~sck_last_q;
      sck_fall <= ~sck_q[1] & sck_last_q;
      cs_fall <= ~cs_q[1] & cs_last_q;
      cs_rise <= cs_q[1] & ~cs_last_q;
      mosi_s <= mosi_q[1];
    end
  end
endmodule // sfseq_sync
`default_nettype wire

// File: hw/sfseq_timer.v
// self-timed operation counter that drives the busy flag
`timescale 1ns/100ps
`default_nettype none
module sfseq_timer (
  input wire clock, // system clock
  input wire nrst, // sync reset, active low
  input wire start, // one-cycle pulse, loads the count
  input wire [23:0] load, // duration in clock cycles
  output reg busy // high while the operation runs
);
  reg [23:0] count_q;

  // ----------------------------------------
  // down counter
  // ----------------------------------------
  // a zero load still gives one busy cycle
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      count_q <= 24'h000000;
      busy <= 1'b0;
    end
    else if (start)
    begin
      count_q <= load;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (count_q <= 24'h000001)
      begin
        busy <= 1'b0;
        count_q <= 24'h000000;
      end
      else
        count_q <= count_q - 24'h000001;
    end
  end
endmodule // sfseq_timer
`default_nettype wire

// File: hw/sfseq_top.v
// serial flash command sequencer behind the spi slave pins
//
// How it works
// - every opcode, address, data or dummy byte spans exactly eight clocks
// - only address bits 15..0 matter; the top address byte is ignored
// - opcode 03h plus three address bytes starts a normal read
// - reads keep streaming bytes, address advancing, while select stays low
// - read address wraps from the top byte back to zero
// - opcode 0bh plus three address bytes starts a fast read
// - fast read waits one dummy byte before driving data
// - opcode 02h, three address bytes, one data byte msb first programs
// - program or erase aimed at a protected area is dropped
// - self-timed work begins only when select rises after the last bit
// - busy stays set for the whole self-timed operation
// - opcode afh programs sequentially; later bytes send afh plus data only
// - host ends sequential mode with 04h then polls busy
// - sequential mode stops at the top unprotected address and clears latch
// - 20h erases the 4 kbyte sector picked by address bits 15..12
// - 52h or d8h erases the 32 kbyte block picked by bit 15
// - 60h or c7h erases everything, unless any area is protected
// - status write acts only straight after the arm command
// - id read: bit 0 picks maker or device code, alternating until deselect
// - status read repeats the status byte every eight clocks
// - bits sampled on rising clock, msb first, framed by select falling
// - select rising mid-instruction aborts it back to standby
// - write unlock sets the write permit latch
// - write lock clears the latch and sequential mode
`include "sfseq_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module sfseq_top #(
  parameter [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter [7:0] DEVICE_CODE = 8'ha5, // arbitrary value
  parameter [23:0] BYTE_PROGRAM_CYCLES = `SFSEQ_BYTE_PROGRAM_CYCLES,
  parameter [23:0] SECTOR_ERASE_CYCLES = `SFSEQ_SECTOR_ERASE_CYCLES,
  parameter [23:0] BLOCK_ERASE_CYCLES = `SFSEQ_BLOCK_ERASE_CYCLES,
  parameter [23:0] CHIP_ERASE_CYCLES = `SFSEQ_CHIP_ERASE_CYCLES
) (
  input wire clock, // system clock, 100 mhz
  input wire nrst, // sync reset, active low
  input wire sck, // serial clock pin
  input wire cs_n, // chip select pin, active low
  input wire mosi, // serial data in pin
  output reg miso, // serial data out
  output reg miso_oe, // high while miso is driven
  input wire [1:0] protect_level, // 0 none, 1 quarter, 2 half, 3 all
  input wire [7:0] status_other, // status bits held outside this block
  output reg [15:0] mem_rd_addr, // array read address
  input wire [7:0] mem_rd_data, // array read data, one cycle later
  output reg prog_req, // one-cycle program pulse
  output reg [15:0] prog_addr, // program address
  output reg [7:0] prog_data, // program data
  output reg erase_req, // one-cycle erase pulse
  output reg [1:0] erase_kind, // sector, block or chip
  output reg [15:0] erase_addr, // erase base address
  output reg status_wr, // one-cycle status write pulse
  output reg [7:0] status_wr_data, // status write data
  output wire busy, // self-timed operation running
  output reg write_permit_latch, // writes allowed
  output reg sequential_program_mode // sequential programming active
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_OP = 7'h02;
  localparam [6:0] ST_ADDR = 7'h04;
  localparam [6:0] ST_DUMMY = 7'h08;
  localparam [6:0] ST_DIN = 7'h10;
  localparam [6:0] ST_DOUT = 7'h20;
  localparam [6:0] ST_DONE = 7'h40;

  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire mosi_s;
  reg [6:0] state_q;
  reg [2:0] bitcnt_q;
  reg [7:0] sr_q;
  reg [7:0] op_q;
  reg [1:0] abyte_q;
  reg [15:0] addr_q;
  reg [7:0] din_q;
  reg [7:0] out_q;
  reg id_sel_q;
  reg arm_q;
  reg [15:0] seq_addr_q;
  reg tstart_q;
  reg [23:0] tload_q;
  wire byte_done;
  wire [7:0] byte_in;
  wire w_ok;
  wire [15:0] seq_next;
  wire [7:0] status_byte;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // protection grows downward from the top, so testing the
  // highest address of a region covers the whole region
  function prot;
    input [15:0] a;
    input [1:0] lvl;
    begin
      case (lvl)
        2'h0: prot = 1'b0;
        2'h1: prot = (a >= `SFSEQ_PROT_QUARTER_BASE);
        2'h2: prot = (a >= `SFSEQ_PROT_HALF_BASE);
        default: prot = 1'b1;
      endcase
    end
  endfunction

  function [15:0] top_unprot;
    input [1:0] lvl;
    begin
      case (lvl)
        2'h0: top_unprot = `SFSEQ_TOP_ADDR;
        2'h1: top_unprot = `SFSEQ_TOP_QUARTER;
        default: top_unprot = `SFSEQ_TOP_HALF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  sfseq_sync u_sync (
    .clock(clock),
    .nrst(nrst),
    .sck(sck),
    .cs_n(cs_n),
    .mosi(mosi),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .cs_fall(cs_fall),
    .cs_rise(cs_rise),
    .mosi_s(mosi_s)
  );

  sfseq_timer u_timer (
    .clock(clock),
    .nrst(nrst),
    .start(tstart_q),
    .load(tload_q),
    .busy(busy)
  );

  // byte boundaries and status assembly
  assign byte_done = sck_rise && (bitcnt_q == 3'h7);
  assign byte_in = {sr_q[6:0], mosi_s};
  assign w_ok = write_permit_latch && !busy;
  assign seq_next = seq_addr_q + 16'h0001;
  assign status_byte = {status_other[7], sequential_program_mode, status_other[5:2],
    write_permit_latch, busy};

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one process keeps shift, decode and execution in step;
  // the pin side is slow enough that a single pass per edge suffices
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      bitcnt_q <= 3'h0;
      sr_q <= 8'h00;
      op_q <= 8'h00;
      abyte_q <= 2'h0;
      addr_q <= 16'h0000;
      din_q <= 8'h00;
      out_q <= 8'h00;
      id_sel_q <= 1'b0;
      arm_q <= 1'b0;
      seq_addr_q <= 16'h0000;
      tstart_q <= 1'b0;
      tload_q <= 24'h000000;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      mem_rd_addr <= 16'h0000;
      prog_req <= 1'b0;
      prog_addr <= 16'h0000;
      prog_data <= 8'h00;
      erase_req <= 1'b0;
      erase_kind <= `SFSEQ_ERASE_SECTOR;
      erase_addr <= 16'h0000;
      status_wr <= 1'b0;
      status_wr_data <= 8'h00;
      write_permit_latch <= 1'b0;
      sequential_program_mode <= 1'b0;
    end
    else
    begin
      tstart_q <= 1'b0;
      prog_req <= 1'b0;
      erase_req <= 1'b0;
      status_wr <= 1'b0;
      mem_rd_addr <= addr_q;
      if (cs_fall)
      begin
        state_q <= ST_OP;
        bitcnt_q <= 3'h0;
        miso_oe <= 1'b0;
      end
      else if (cs_rise)
      begin
        // anything short of complete is dropped here
        state_q <= ST_IDLE;
        miso_oe <= 1'b0;
        arm_q <= (state_q == ST_DONE) && (op_q == `SFSEQ_OP_STATUS_ARM);
        if (state_q == ST_DONE)
        begin
          // execution waits for deselect
          case (op_q)
            `SFSEQ_OP_WRITE_UNLOCK:
              write_permit_latch <= 1'b1;
            `SFSEQ_OP_WRITE_LOCK:
            begin
              write_permit_latch <= 1'b0;
              sequential_program_mode <= 1'b0;
            end
            `SFSEQ_OP_STATUS_WRITE:
              if (arm_q)
              begin
                status_wr <= 1'b1;
                status_wr_data <= din_q;
              end
            `SFSEQ_OP_PROGRAM:
              if (w_ok && !prot(addr_q, protect_level))
              begin
                prog_req <= 1'b1;
                prog_addr <= addr_q;
                prog_data <= din_q;
                tstart_q <= 1'b1;
                tload_q <= BYTE_PROGRAM_CYCLES;
                write_permit_latch <= 1'b0;
              end
            `SFSEQ_OP_SEQ_PROGRAM:
              if (!sequential_program_mode)
              begin
                if (w_ok && !prot(addr_q, protect_level))
                begin
                  prog_req <= 1'b1;
                  prog_addr <= addr_q;
                  prog_data <= din_q;
                  tstart_q <= 1'b1;
                  tload_q <= BYTE_PROGRAM_CYCLES;
                  seq_addr_q <= addr_q;
                  // a start right on the last free byte ends at once
                  sequential_program_mode <= (addr_q != top_unprot(protect_level));
                  write_permit_latch <= (addr_q != top_unprot(protect_level));
                end
              end
              else if (!busy)
              begin
                prog_req <= 1'b1;
                prog_addr <= seq_next;
                prog_data <= din_q;
                tstart_q <= 1'b1;
                tload_q <= BYTE_PROGRAM_CYCLES;
                seq_addr_q <= seq_next;
                if (seq_next == top_unprot(protect_level))
                begin
                  sequential_program_mode <= 1'b0;
                  write_permit_latch <= 1'b0;
                end
              end
            `SFSEQ_OP_SECTOR_ERASE:
              if (w_ok && !prot(addr_q | `SFSEQ_SECTOR_MASK, protect_level))
              begin
                erase_req <= 1'b1;
                erase_kind <= `SFSEQ_ERASE_SECTOR;
                erase_addr <= addr_q & ~`SFSEQ_SECTOR_MASK;
                tstart_q <= 1'b1;
                tload_q <= SECTOR_ERASE_CYCLES;
                write_permit_latch <= 1'b0;
              end
            `SFSEQ_OP_BLOCK_ERASE_A, `SFSEQ_OP_BLOCK_ERASE_B:
              if (w_ok && !prot(addr_q | `SFSEQ_BLOCK_MASK, protect_level))
              begin
                erase_req <= 1'b1;
                erase_kind <= `SFSEQ_ERASE_BLOCK;
                erase_addr <= addr_q & ~`SFSEQ_BLOCK_MASK;
                tstart_q <= 1'b1;
                tload_q <= BLOCK_ERASE_CYCLES;
                write_permit_latch <= 1'b0;
              end
            `SFSEQ_OP_CHIP_ERASE_A, `SFSEQ_OP_CHIP_ERASE_B:
              if (w_ok && (protect_level == 2'h0))
              begin
                erase_req <= 1'b1;
                erase_kind <= `SFSEQ_ERASE_CHIP;
                erase_addr <= 16'h0000;
                tstart_q <= 1'b1;
                tload_q <= CHIP_ERASE_CYCLES;
                write_permit_latch <= 1'b0;
              end
            default:
              write_permit_latch <= write_permit_latch;
          endcase
        end
      end
      else if (sck_rise && (state_q != ST_IDLE))
      begin
        sr_q <= byte_in;
        bitcnt_q <= bitcnt_q + 3'h1;
        if (byte_done)
        begin
          case (state_q)
            ST_OP:
            begin
              op_q <= byte_in;
              abyte_q <= 2'h0;
              case (byte_in)
                `SFSEQ_OP_READ, `SFSEQ_OP_FAST_READ, `SFSEQ_OP_PROGRAM,
                `SFSEQ_OP_SECTOR_ERASE, `SFSEQ_OP_BLOCK_ERASE_A, `SFSEQ_OP_BLOCK_ERASE_B,
                `SFSEQ_OP_ID_READ_A, `SFSEQ_OP_ID_READ_B:
                  state_q <= ST_ADDR;
                `SFSEQ_OP_SEQ_PROGRAM:
                  state_q <= sequential_program_mode ? ST_DIN : ST_ADDR;
                `SFSEQ_OP_STATUS_READ:
                  state_q <= ST_DOUT;
                `SFSEQ_OP_STATUS_WRITE:
                  state_q <= ST_DIN;
                default:
                  state_q <= ST_DONE;
              endcase
            end
            ST_ADDR:
            begin
              abyte_q <= abyte_q + 2'h1;
              // first address byte is dropped
              if (abyte_q == 2'h1)
                addr_q[15:8] <= byte_in;
              if (abyte_q == 2'h2)
              begin
                addr_q[7:0] <= byte_in;
                id_sel_q <= byte_in[0];
                case (op_q)
                  `SFSEQ_OP_READ, `SFSEQ_OP_ID_READ_A, `SFSEQ_OP_ID_READ_B:
                    state_q <= ST_DOUT;
                  `SFSEQ_OP_FAST_READ:
                    state_q <= ST_DUMMY;
                  `SFSEQ_OP_PROGRAM, `SFSEQ_OP_SEQ_PROGRAM:
                    state_q <= ST_DIN;
                  default:
                    state_q <= ST_DONE;
                endcase
              end
            end
            ST_DUMMY:
              state_q <= ST_DOUT;
            ST_DIN:
            begin
              din_q <= byte_in;
              state_q <= ST_DONE;
            end
            default:
              state_q <= state_q;
          endcase
        end
      end
      else if (sck_fall && (state_q == ST_DOUT))
      begin
        miso_oe <= 1'b1;
        if (bitcnt_q == 3'h0)
        begin
          // new byte at each boundary; the array had a full byte time to answer, but only half a clock for the first byte of a 03h read
          case (op_q)
            `SFSEQ_OP_STATUS_READ:
            begin
              out_q <= status_byte;
              miso <= status_byte[7];
            end
            `SFSEQ_OP_ID_READ_A, `SFSEQ_OP_ID_READ_B:
            begin
              out_q <= id_sel_q ? DEVICE_CODE : MAKER_CODE;
              miso <= id_sel_q ? DEVICE_CODE[7] : MAKER_CODE[7];
              id_sel_q <= ~id_sel_q;
            end
            default:
            begin
              out_q <= mem_rd_data;
              miso <= mem_rd_data[7];
              addr_q <= addr_q + 16'h0001;
            end
          endcase
        end
        else
          miso <= out_q[3'h7 - bitcnt_q];
      end
    end
  end
endmodule // sfseq_top
`default_nettype wire

// File: testbench/sfseq_properties.sv
// assertion checker for the serial flash sequencer
`timescale 1ns/100ps
`default_nettype none
module sfseq_props (
  input wire logic clock, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic sck, // serial clock pin
  input wire logic cs_n, // chip select pin
  input wire logic miso, // serial data out
  input wire logic miso_oe, // data out driven
  input wire logic [1:0] protect_level, // protected area
  input wire logic prog_req, // program pulse
  input wire logic [15:0] prog_addr, // program address
  input wire logic erase_req, // erase pulse
  input wire logic [1:0] erase_kind, // erase kind
  input wire logic [15:0] erase_addr, // erase base
  input wire logic busy, // self-timed work running
  input wire logic write_permit_latch, // writes allowed
  input wire logic sequential_program_mode // sequential mode
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----
  // properties
  // ----
  property p_oe_idle; cs_n [*8] |-> !miso_oe; endproperty
  property p_busy_run; $rose(busy) |-> busy [*8]; endproperty
  property p_prog_start; prog_req |-> !busy ##1 busy; endproperty
  property p_prog_gate; prog_req |-> $past(write_permit_latch) && cs_n; endproperty
  property p_erase_gate; erase_req |-> $past(write_permit_latch) && !busy ##1 busy; endproperty
  property p_chip_prot; erase_req && erase_kind == 2'h2 |-> protect_level == 2'h0; endproperty
  property p_erase_base;
    erase_req |-> (erase_kind == 2'h0 && erase_addr[11:0] == 12'h000) ||
      (erase_kind == 2'h1 && erase_addr[14:0] == 15'h0000) || (erase_kind == 2'h2 && erase_addr == 16'h0000);
  endproperty
  property p_prot_prog;
    prog_req |-> protect_level != 2'h3 && !(protect_level == 2'h2 && prog_addr[15]) &&
      !(protect_level == 2'h1 && prog_addr[15:14] == 2'h3);
  endproperty
  property p_miso_fall; miso_oe && $past(miso_oe) && $changed(miso) |-> !$past(sck, 3); endproperty
  property p_seq_top;
    prog_req && protect_level == 2'h0 && prog_addr == 16'hffff |-> !sequential_program_mode && !write_permit_latch;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data out driven while deselected");
  a_busy_run: assert property (p_busy_run) else $error("busy dropped early");
  a_prog_start: assert property (p_prog_start) else $error("program not followed by busy");
  a_prog_gate: assert property (p_prog_gate) else $error("program without latch");
  a_erase_gate: assert property (p_erase_gate) else $error("erase without latch or busy");
  a_chip_prot: assert property (p_chip_prot) else $error("chip erase while protected");
  a_erase_base: assert property (p_erase_base) else $error("erase base not aligned");
  a_prot_prog: assert property (p_prot_prog) else $error("program into protected area");
  a_miso_fall: assert property (p_miso_fall) else $error("data out moved off a falling edge");
  a_seq_top: assert property (p_seq_top) else $error("sequential mode kept at top");
  c_prog: cover property (prog_req);
  c_erase: cover property (erase_req && erase_kind == 2'h2);
  c_read: cover property ($rose(miso_oe));
endmodule // sfseq_props
`default_nettype wire

// File: testbench/sfseq_host.sv
// spi host model driving the serial flash pins
`timescale 1ns/100ps
`default_nettype none
module sfseq_host (
  output var logic sck, // serial clock, stands low outside frames
  output var logic cs_n, // chip select, active low
  output var logic mosi, // data to the device
  input wire logic miso // data from the device
);
  // pins start deselected
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // select stays low until close_frame
  task open_frame;
    begin
      cs_n = 1'b0;
      #62.5;
    end
  endtask
  // eight clocks, msb first, device data taken on the rising edge
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i--)
      begin
        mosi = tx[i];
        #62.5 sck = 1'b1;
        rx[i] = miso;
        #62.5 sck = 1'b0;
      end
    end
  endtask
  // deselect; released data line shows the inverse, not a held value
  task close_frame;
    begin
      #62.5 cs_n = 1'b1;
      mosi = ~mosi;
      #100;
    end
  endtask
endmodule // sfseq_host
`default_nettype wire

// File: testbench/sfseq_top_test.sv
// self-checking bench for the serial flash sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sfseq_regs.vh"
module sfseq_top_test;
  logic clock, nrst, sck, cs_n, mosi, miso, miso_oe, prog_req, erase_req, status_wr, busy;
  logic write_permit_latch, sequential_program_mode;
  logic [1:0] protect_level, erase_kind;
  logic [7:0] status_other, mem_rd_data, prog_data, status_wr_data;
  logic [7:0] rb [0:3];
  logic [15:0] mem_rd_addr, prog_addr, erase_addr;
  integer error_cnt = 0, tests_run = 0, n_prog = 0, n_erase = 0, n_swr = 0, i;
  // short self-timed counts keep the run brief
  sfseq_top #(.BYTE_PROGRAM_CYCLES(24'd20), .SECTOR_ERASE_CYCLES(24'd30), .BLOCK_ERASE_CYCLES(24'd30),
    .CHIP_ERASE_CYCLES(24'd40)) sfseq_top_i (.clock, .nrst, .sck, .cs_n, .mosi, .miso, .miso_oe,
    .protect_level, .status_other, .mem_rd_addr, .mem_rd_data, .prog_req, .prog_addr, .prog_data, .erase_req,
    .erase_kind, .erase_addr, .status_wr, .status_wr_data, .busy, .write_permit_latch, .sequential_program_mode);
  sfseq_host sfseq_host_i (.sck, .cs_n, .mosi, .miso);
  // array contents as a pattern of the address
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // array model with one cycle of latency
  always @(posedge clock) mem_rd_data <= pat(mem_rd_addr);
  // pulse counters
  always @(posedge clock)
  begin
    n_prog <= n_prog + (prog_req === 1'b1);
    n_erase <= n_erase + (erase_req === 1'b1);
    n_swr <= n_swr + (status_wr === 1'b1);
  end
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // one frame: opcode, optional address, nd copies of d, nr bytes read into rb
  task cmd(input logic [7:0] op, input logic ha, input logic [23:0] a, input integer nd, input logic [7:0] d,
    input integer nr);
    logic [7:0] x;
    integer k;
    begin
      sfseq_host_i.open_frame;
      sfseq_host_i.xfer(op, x);
      if (ha) for (k = 2; k >= 0; k--) sfseq_host_i.xfer(a[8*k +: 8], x);
      for (k = 0; k < nd; k++) sfseq_host_i.xfer(d, x);
      for (k = 0; k < nr; k++) sfseq_host_i.xfer(8'h00, rb[k]);
      sfseq_host_i.close_frame;
      @(posedge clock) #1;
    end
  endtask
  task unlock;
    cmd(`SFSEQ_OP_WRITE_UNLOCK, 0, 0, 0, 8'h00, 0);
  endtask
  // bounded wait for self-timed work; ends just after an edge
  task wait_idle;
    integer k;
    begin
      for (k = 0; k < 500 && busy !== 1'b0; k++) @(posedge clock);
      @(posedge clock);
      #1;
      if (busy !== 1'b0) error_cnt++;
    end
  endtask
  // hang guard
  initial
  begin
    #900000;
    error_cnt++;
    report_and_stop;
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    nrst = 1'b0;
    protect_level = 2'h0;
    status_other = 8'hff;
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    chk({busy, write_permit_latch, sequential_program_mode, miso_oe}, 16'h0000);
    wait_idle;
    cmd(`SFSEQ_OP_READ, 1, 24'h5afffe, 0, 8'h00, 3);
    for (i = 0; i < 3; i++) chk(rb[i], pat(16'(16'hfffe + i)));
    cmd(`SFSEQ_OP_FAST_READ, 1, 24'h001234, 1, 8'h00, 2);
    for (i = 0; i < 2; i++) chk(rb[i], pat(16'(16'h1234 + i)));
    cmd(`SFSEQ_OP_ID_READ_A, 1, 24'h000001, 0, 8'h00, 3);
    chk({rb[0], rb[1]}, 16'ha55a);
    chk({rb[2], 8'h00}, 16'ha500);
    cmd(`SFSEQ_OP_ID_READ_B, 1, 24'h000000, 0, 8'h00, 2);
    chk({rb[0], rb[1]}, 16'h5aa5);
    unlock;
    cmd(`SFSEQ_OP_STATUS_READ, 0, 0, 0, 8'h00, 2);
    chk({rb[0], rb[1]}, 16'hbebe);
    cmd(`SFSEQ_OP_PROGRAM, 1, 24'hff00c3, 1, 8'h96, 0);
    chk(prog_addr, 16'h00c3);
    chk({prog_data, 6'h00, busy, write_permit_latch}, 16'h9602);
    chk(n_prog[15:0], 16'h0001);
    wait_idle;
    // cut short, then aimed at the protected quarter: neither may program
    unlock;
    cmd(`SFSEQ_OP_PROGRAM, 0, 0, 1, 8'h00, 0);
    protect_level = 2'h1;
    cmd(`SFSEQ_OP_PROGRAM, 1, 24'h00c000, 1, 8'h55, 0);
    chk({n_prog[14:0], write_permit_latch}, 16'h0003);
    for (i = 0; i < 3; i++)
    begin
      protect_level = i[1:0] + 2'h1;
      unlock;
      cmd(i == 0 ? `SFSEQ_OP_SECTOR_ERASE : i == 1 ? `SFSEQ_OP_BLOCK_ERASE_A : `SFSEQ_OP_BLOCK_ERASE_B,
        1, 24'h003456, 0, 8'h00, 0);
      chk(erase_addr, i == 0 ? 16'h3000 : 16'h0000);
      chk({erase_kind, n_erase[13:0]}, i == 0 ? 16'h0001 : 16'h4002);
      wait_idle;
    end
    unlock;
    cmd(`SFSEQ_OP_CHIP_ERASE_A, 0, 0, 0, 8'h00, 0);
    chk(n_erase[15:0], 16'h0002);
    wait_idle;
    protect_level = 2'h0;
    unlock;
    cmd(`SFSEQ_OP_CHIP_ERASE_B, 0, 0, 0, 8'h00, 0);
    chk({erase_kind, n_erase[13:0]}, 16'h8003);
    wait_idle;
    // sequential programming stopped by write lock, then started right on the top address
    unlock;
    cmd(`SFSEQ_OP_SEQ_PROGRAM, 1, 24'h000100, 1, 8'h11, 0);
    chk({prog_addr[7:0], prog_data}, 16'h0011);
    chk({14'h0000, sequential_program_mode, write_permit_latch}, 16'h0003);
    wait_idle;
    cmd(`SFSEQ_OP_SEQ_PROGRAM, 0, 0, 1, 8'h22, 0);
    chk({prog_addr[7:0], prog_data}, 16'h0122);
    wait_idle;
    cmd(`SFSEQ_OP_WRITE_LOCK, 0, 0, 0, 8'h00, 0);
    chk({14'h0000, sequential_program_mode, write_permit_latch}, 16'h0000);
    unlock;
    cmd(`SFSEQ_OP_SEQ_PROGRAM, 1, 24'h00ffff, 1, 8'h33, 0);
    chk(prog_addr, 16'hffff);
    chk({n_prog[13:0], sequential_program_mode, write_permit_latch}, 16'h0010);
    wait_idle;
    cmd(`SFSEQ_OP_STATUS_ARM, 0, 0, 0, 8'h00, 0);
    cmd(`SFSEQ_OP_STATUS_WRITE, 0, 0, 1, 8'h3c, 0);
    chk({n_swr[7:0], status_wr_data}, 16'h013c);
    cmd(`SFSEQ_OP_STATUS_ARM, 0, 0, 0, 8'h00, 0);
    cmd(`SFSEQ_OP_STATUS_READ, 0, 0, 0, 8'h00, 1);
    cmd(`SFSEQ_OP_STATUS_WRITE, 0, 0, 1, 8'h0c, 0);
    chk({n_swr[7:0], status_wr_data}, 16'h013c);
    report_and_stop;
  end
endmodule // sfseq_top_test
bind sfseq_top sfseq_props sfseq_props_i (.clock, .nrst, .sck, .cs_n, .miso, .miso_oe, .protect_level, .prog_req,
  .prog_addr, .erase_req, .erase_kind, .erase_addr, .busy, .write_permit_latch, .sequential_program_mode);
`default_nettype wire
